// ---- design/rss_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none


module rss_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned POWER_ON_CYC    = POWER_ON_DELAY_CYC,
    parameter int unsigned BROWN_OUT_CYC   = BROWN_OUT_DELAY_CYC,
    parameter int unsigned HOLD_CYC        = POWER_UP_HOLD_PERIOD_CYC,
    parameter int unsigned OSC_START_CYC   = OSC_START_DELAY_CYC,
    parameter int unsigned MONITOR_CYC     = MONITOR_START_DELAY_CYC
)
(
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic                    power_on_active,
    input  wire logic                    brown_out_low,
    input  wire logic                    hold_timer_enable,
    input  wire logic                    monitor_enable,
    output logic                         system_reset_out,
    output logic                         osc_enable,
    output logic                         clock_ready,
    output logic                         fetch_start,
    output logic [FETCH_ADDR_W-1:0]      fetch_addr,
    output logic                         clock_failure_monitor
);

    if (POWER_ON_CYC < 1 || BROWN_OUT_CYC < 1 || HOLD_CYC < 1 ||
        OSC_START_CYC < 1 || MONITOR_CYC < 1)
    begin : g_bad_count
        $error("rss_sequencer: delay counts must be at least one");
    end

    typedef struct packed
    {
        rss_state_t        st;
        logic [CNT_W-1:0]  por_cnt;
        logic [CNT_W-1:0]  bor_cnt;
        logic [CNT_W-1:0]  cnt;
        logic              por_done;
        logic              bor_done;
        logic              rst_out;
        logic              ready;
        logic              fetch;
        logic              monitor;
        logic [CNT_W-1:0]  since_rel;
    } rss_seq_t;

    rss_seq_t state;
    rss_seq_t next_state;
    logic     por_lvl;
    logic     bor_lvl;

    // Detector outputs are asynchronous pins
    rss_pin_sync #(.INIT(1'b1)) u_por_sync
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (power_on_active),
        .level   (por_lvl)
    );

    rss_pin_sync #(.INIT(1'b1)) u_bor_sync
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (brown_out_low),
        .level   (bor_lvl)
    );

    function automatic logic [CNT_W-1:0] last_of(input int unsigned n);
        last_of = CNT_W'(n - 1);
    endfunction : last_of

    always_comb
    begin
        next_state       = state;
        next_state.fetch = 1'b0;
        // Cycles since release, kept only for the timing checks
        if (state.rst_out)
        begin
            next_state.since_rel = '0;
        end
        else if (state.since_rel != '1)
        begin
            next_state.since_rel = state.since_rel + 1'b1;
        end
        // Power-on delay restarts whenever the detector re-asserts
        if (por_lvl)
        begin
            next_state.por_cnt  = '0;
            next_state.por_done = 1'b0;
        end
        else if (!state.por_done)
        begin
            if (state.por_cnt == last_of(POWER_ON_CYC))
            begin
                next_state.por_done = 1'b1;
            end
            else
            begin
                next_state.por_cnt = state.por_cnt + 1'b1;
            end
        end
        if (bor_lvl)
        begin
            next_state.bor_cnt  = '0;
            next_state.bor_done = 1'b0;
        end
        else if (!state.bor_done)
        begin
            if (state.bor_cnt == last_of(BROWN_OUT_CYC))
            begin
                next_state.bor_done = 1'b1;
            end
            else
            begin
                next_state.bor_cnt = state.bor_cnt + 1'b1;
            end
        end
        // Any detector dropping back restarts the whole sequence
        if (por_lvl || bor_lvl || !state.por_done || !state.bor_done)
        begin
            next_state.st      = RSS_ST_DETECT;
            next_state.cnt     = '0;
            next_state.rst_out = 1'b1;
            next_state.ready   = 1'b0;
            next_state.monitor = 1'b0;
        end
        else
        begin
            case (state.st)
                RSS_ST_DETECT:
                begin
                    next_state.cnt = '0;
                    // Hold timer off skips straight to release
                    if (hold_timer_enable)
                    begin
                        next_state.st = RSS_ST_HOLD;
                    end
                    else
                    begin
                        next_state.st      = RSS_ST_OSC;
                        next_state.rst_out = 1'b0;
                    end
                end
                RSS_ST_HOLD:
                begin
                    if (state.cnt == last_of(HOLD_CYC))
                    begin
                        next_state.cnt     = '0;
                        next_state.st      = RSS_ST_OSC;
                        next_state.rst_out = 1'b0;
                    end
                    else
                    begin
                        next_state.cnt = state.cnt + 1'b1;
                    end
                end
                RSS_ST_OSC:
                begin
                    if (state.cnt == last_of(OSC_START_CYC))
                    begin
                        next_state.cnt   = '0;
                        next_state.st    = RSS_ST_RUN_WAIT;
                        next_state.ready = 1'b1;
                        next_state.fetch = 1'b1;
                    end
                    else
                    begin
                        next_state.cnt = state.cnt + 1'b1;
                    end
                end
                RSS_ST_RUN_WAIT:
                begin
                    if (state.cnt == last_of(MONITOR_CYC))
                    begin
                        next_state.st      = RSS_ST_RUN;
                        next_state.monitor = monitor_enable;
                    end
                    else
                    begin
                        next_state.cnt = state.cnt + 1'b1;
                    end
                end
                RSS_ST_RUN:
                begin
                    // Enable is a configuration level; sampled live
                    next_state.monitor = monitor_enable;
                end
                default:
                begin
                    next_state.st = RSS_ST_DETECT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '{st: RSS_ST_DETECT, rst_out: 1'b1, default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign system_reset_out      = state.rst_out;
    assign osc_enable            = !state.rst_out;
    assign clock_ready           = state.ready;
    assign fetch_start           = state.fetch;
    assign fetch_addr            = RESET_FETCH_ADDR;
    assign clock_failure_monitor = state.monitor;

    property p_por_holds;
        @(posedge ref_clk) disable iff (!rstn)
        por_lvl |=> system_reset_out;
    endproperty
    a_por_holds: assert property (p_por_holds)
        else $error("reset released with power-on detector active");

    property p_bor_holds;
        @(posedge ref_clk) disable iff (!rstn)
        bor_lvl |=> system_reset_out && !clock_ready;
    endproperty
    a_bor_holds: assert property (p_bor_holds)
        else $error("reset released with brown-out active");

    property p_hold_period;
        @(posedge ref_clk) disable iff (!rstn)
        $fell(system_reset_out) && hold_timer_enable
            |-> $past(state.st) == RSS_ST_HOLD;
    endproperty
    a_hold_period: assert property (p_hold_period)
        else $error("reset released without hold period");

    property p_release_osc;
        @(posedge ref_clk) disable iff (!rstn)
        $fell(system_reset_out) |-> osc_enable && state.st == RSS_ST_OSC;
    endproperty
    a_release_osc: assert property (p_release_osc)
        else $error("oscillator enable not tied to reset release");

    property p_fetch_zero;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(clock_ready) |-> fetch_start && fetch_addr == 24'h000000;
    endproperty
    a_fetch_zero: assert property (p_fetch_zero)
        else $error("fetch not started at zero on clock ready");

    property p_monitor_late;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(clock_failure_monitor) |-> clock_ready &&
            state.since_rel >= CNT_W'(OSC_START_CYC + MONITOR_CYC);
    endproperty
    a_monitor_late: assert property (p_monitor_late)
        else $error("monitor started before its delay");

    property p_ready_delay;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(clock_ready) |-> state.since_rel == CNT_W'(OSC_START_CYC);
    endproperty
    a_ready_delay: assert property (p_ready_delay)
        else $error("clock ready at wrong count after release");

    property p_fetch_pulse;
        @(posedge ref_clk) disable iff (!rstn)
        fetch_start |=> !fetch_start;
    endproperty
    a_fetch_pulse: assert property (p_fetch_pulse)
        else $error("fetch start longer than one cycle");

    c_release: cover property (@(posedge ref_clk) disable iff (!rstn)
        $fell(system_reset_out));
    c_ready: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(clock_ready));
    c_monitor: cover property (@(posedge ref_clk) disable iff (!rstn)
        $rose(clock_failure_monitor));
    c_brownout: cover property (@(posedge ref_clk) disable iff (!rstn)
        clock_ready && bor_lvl);

endmodule : rss_sequencer

`default_nettype wire

// ---- pkg/rss_pkg.sv ----
package rss_pkg;

    // Reference clock rate in megahertz
    localparam int unsigned REF_CLK_MHZ           = 200;

    // Delays in microseconds, defaults of plain value
    localparam int unsigned POWER_ON_DELAY_US     = 10;
    localparam int unsigned BROWN_OUT_DELAY_US    = 10;
    localparam int unsigned MONITOR_START_DELAY_US = 2;

    // Least times round up to whole cycles, never below one
    localparam int unsigned POWER_ON_DELAY_CYC =
        (POWER_ON_DELAY_US * REF_CLK_MHZ < 1) ? 1 :
        POWER_ON_DELAY_US * REF_CLK_MHZ;
    localparam int unsigned BROWN_OUT_DELAY_CYC =
        (BROWN_OUT_DELAY_US * REF_CLK_MHZ < 1) ? 1 :
        BROWN_OUT_DELAY_US * REF_CLK_MHZ;
    localparam int unsigned MONITOR_START_DELAY_CYC =
        (MONITOR_START_DELAY_US * REF_CLK_MHZ < 1) ? 1 :
        MONITOR_START_DELAY_US * REF_CLK_MHZ;

    // Power-up hold period in milliseconds; above 4096 cycles, so the
    // top module carries it as a parameter
    localparam int unsigned POWER_UP_HOLD_PERIOD_MS  = 64;
    localparam int unsigned POWER_UP_HOLD_PERIOD_CYC =
        POWER_UP_HOLD_PERIOD_MS * REF_CLK_MHZ * 1000;

    // Default oscillator start-up count
    localparam int unsigned OSC_START_DELAY_CYC   = 1024;

    // Counter width
    localparam int unsigned CNT_W                 = 32;

    // Fetch start address and width
    localparam int unsigned FETCH_ADDR_W          = 24;
    localparam logic [23:0] RESET_FETCH_ADDR      = 24'h000000;

    typedef enum logic [2:0]
    {
        RSS_ST_DETECT  = 3'b000,
        RSS_ST_HOLD    = 3'b001,
        RSS_ST_OSC     = 3'b010,
        RSS_ST_RUN_WAIT = 3'b011,
        RSS_ST_RUN     = 3'b100
    } rss_state_t;

endpackage : rss_pkg

// ---- design/rss_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module rss_pin_sync
    import rss_pkg::*;
#(
    parameter logic INIT = 1'b1
)
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level
);

    typedef struct packed
    {
        logic [2:0] stage;
        logic       level;
    } rss_sync_t;

    rss_sync_t state;
    rss_sync_t next_state;

    // First stage feeds only the second; a change counts once two and
    // three agree, which filters a single-cycle glitch
    always_comb
    begin
        next_state       = state;
        next_state.stage = {state.stage[1:0], pin};
        if (state.stage[1] == state.stage[2])
        begin
            next_state.level = state.stage[2];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '{stage: {3{INIT}}, level: INIT};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule : rss_pin_sync

`default_nettype wire

// ---- tb/rss_sequencer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module rss_sequencer_tb
    import rss_pkg::*;
;
    // Short counts keep the run brief
    localparam int PO   = 5;
    localparam int BO   = 5;
    localparam int HOLD = 20;
    localparam int OSC  = 8;
    localparam int MON  = 4;

    logic        ref_clk           = 1'b0;
    logic        rstn              = 1'b0;
    logic        power_on_active   = 1'b1;
    logic        brown_out_low     = 1'b1;
    logic        hold_timer_enable = 1'b1;
    logic        monitor_enable    = 1'b0;
    logic        system_reset_out;
    logic        osc_enable;
    logic        clock_ready;
    logic        fetch_start;
    logic [23:0] fetch_addr;
    logic        clock_failure_monitor;
    int          errors    = 0;
    int          tests_run = 0;
    int          seed      = 32'h86791c8f;
    int          n0;
    int          n1;
    int          k;

    always #2.5 ref_clk = ~ref_clk;

    rss_sequencer #(
        .POWER_ON_CYC  (PO),
        .BROWN_OUT_CYC (BO),
        .HOLD_CYC      (HOLD),
        .OSC_START_CYC (OSC),
        .MONITOR_CYC   (MON)
    ) rss_sequencer_i (
        .ref_clk               (ref_clk),
        .rstn                  (rstn),
        .power_on_active       (power_on_active),
        .brown_out_low         (brown_out_low),
        .hold_timer_enable     (hold_timer_enable),
        .monitor_enable        (monitor_enable),
        .system_reset_out      (system_reset_out),
        .osc_enable            (osc_enable),
        .clock_ready           (clock_ready),
        .fetch_start           (fetch_start),
        .fetch_addr            (fetch_addr),
        .clock_failure_monitor (clock_failure_monitor)
    );

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_cnt(input string name, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", name, exp, got);
        end
    endtask : cmp_cnt

    task automatic cmp_addr(input string name, input logic [23:0] exp,
                            input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_addr

    // Least cycles from brown-out release to reset release; a brown-out
    // already low leaves the power-on delay, which began stagger earlier
    function automatic int release_lo(input logic hold_en, input logic early,
                                      input int stagger);
        release_lo = (early ? PO - stagger : BO) + (hold_en ? HOLD : 0);
    endfunction : release_lo

    // Everything downstream of reset must stay quiet
    task automatic check_held;
        cmp_bit("system_reset_out", 1'b1, system_reset_out);
        cmp_bit("osc_enable", 1'b0, osc_enable);
        cmp_bit("clock_ready", 1'b0, clock_ready);
        cmp_bit("fetch_start", 1'b0, fetch_start);
        cmp_bit("monitor", 1'b0, clock_failure_monitor);
    endtask : check_held

    task automatic run_seq(input logic hold_en, input logic mon_en,
                           input int stagger, input logic glitch,
                           output int n);
        int   i;
        int   lo;
        logic early;
        early = !brown_out_low && !glitch;
        hold_timer_enable = hold_en;
        monitor_enable = mon_en;
        power_on_active = 1'b0;
        // Brown-out released last; if already low, power-on governs
        repeat (stagger)
        begin
            @(negedge ref_clk);
            check_held();
        end
        brown_out_low = 1'b0;
        if (glitch)
        begin
            // Dip at the start of the hold period restarts the whole sequence
            repeat (BO + 4)
            begin
                @(negedge ref_clk);
                check_held();
            end
            brown_out_low = 1'b1;
            repeat (4)
            begin
                @(negedge ref_clk);
                check_held();
            end
            brown_out_low = 1'b0;
        end
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
            if (system_reset_out !== 1'b0)
                check_held();
        end while (system_reset_out !== 1'b0 && n < 200);
        lo = release_lo(hold_en, early, stagger);
        cmp_bit("release window", 1'b1, n >= lo && n <= lo + 8);
        cmp_bit("osc_enable", 1'b1, osc_enable);
        for (i = 1; i < OSC; i++)
        begin
            @(negedge ref_clk);
            cmp_bit("clock_ready", 1'b0, clock_ready);
        end
        @(negedge ref_clk);
        cmp_bit("clock_ready", 1'b1, clock_ready);
        cmp_bit("fetch_start", 1'b1, fetch_start);
        cmp_addr("fetch_addr", 24'h000000, fetch_addr);
        for (i = 1; i < MON; i++)
        begin
            @(negedge ref_clk);
            cmp_bit("monitor", 1'b0, clock_failure_monitor);
            if (i == 1)
                cmp_bit("fetch_start", 1'b0, fetch_start);
        end
        @(negedge ref_clk);
        cmp_bit("monitor", mon_en, clock_failure_monitor);
        cmp_bit("clock_ready", 1'b1, clock_ready);
    endtask : run_seq

    // Either detector coming back must pull the system into reset
    task automatic drop(input logic which);
        if (which)
            brown_out_low = 1'b1;
        else
            power_on_active = 1'b1;
        repeat (6) @(negedge ref_clk);
        check_held();
    endtask : drop

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (10) @(negedge ref_clk);
        check_held();
        rstn = 1'b1;
        repeat (8)
        begin
            @(negedge ref_clk);
            check_held();
        end
        run_seq(1'b0, 1'b1, 0, 1'b0, n0);
        drop(1'b0);
        run_seq(1'b1, 1'b1, 0, 1'b0, n1);
        cmp_cnt("hold span", HOLD, n1 - n0);
        drop(1'b1);
        run_seq(1'b1, 1'b0, 3, 1'b1, n1);
        drop(1'b1);
        for (k = 0; k < 8; k++)
        begin
            n0 = $random(seed);
            run_seq(n0[0], n0[1], int'(n0[6:4]), n0[0] & n0[2], n1);
            drop(n0[3]);
        end
        run_seq(1'b1, 1'b1, 2, 1'b0, n1);
        // Asynchronous reset in mid run
        rstn = 1'b0;
        @(negedge ref_clk);
        check_held();
        rstn = 1'b1;
        run_seq(1'b0, 1'b0, 1, 1'b0, n1);
        tally_and_finish();
    end

    // Whole run is under 2000 cycles
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end

endmodule : rss_sequencer_tb

`default_nettype wire
